// [logic/cmdsel_params.svh]
// Purpose: Offsets, field positions and reset values for the command selector
// Assumes: Included by bare name from the design module and the testbench
// Notes:   Byte addresses on a 32-bit AHB-Lite slave, one register per word
`ifndef CMDSEL_PARAMS_SVH
`define CMDSEL_PARAMS_SVH

`define OFS_CHIP_TEST_THREE 8'h00
`define OFS_DMA_MODE        8'h04
`define OFS_CHIP_TEST_FIVE  8'h08
`define OFS_CACHE_LINE_SIZE 8'h0C
`define OFS_CACHE_CTRL      8'h10
`define OFS_PCI_COMMAND     8'h14
`define OFS_STATUS          8'h18

`define BIT_WR_INV_EN       0
`define BIT_DM_READ_LINE    3
`define BIT_DM_READ_MULTI   2
`define BIT_DM_BURST_HI     7
`define BIT_DM_BURST_LO     6
`define BIT_CT5_BURST_EXT   2
`define BIT_CACHE_MODE_EN   0
`define BIT_PCICMD_MWI      4
`define BIT_PCICMD_MASTER   2

`define RST_REG8            8'h00
`define RST_PCICMD          16'h0000
`define DWORD_BYTES         24'h000004
`define ADDR_STEP           32'h00000004

`endif

// [logic/cmdsel_pkg.sv]
// Purpose: Types shared by the command selector modules
// Assumes: Constants live in cmdsel_params.svh
// Notes:   Command codes are the bus encodings driven on the byte-enable lines
package cmdsel_pkg;

    typedef enum logic [3:0] {
        CMD_INT_ACK   = 4'h0,
        CMD_SPECIAL   = 4'h1,
        CMD_IO_READ   = 4'h2,
        CMD_IO_WRITE  = 4'h3,
        CMD_MEM_READ  = 4'h6,
        CMD_MEM_WRITE = 4'h7,
        CMD_CFG_READ  = 4'hA,
        CMD_CFG_WRITE = 4'hB,
        CMD_READ_MULT = 4'hC,
        CMD_DUAL_ADDR = 4'hD,
        CMD_READ_LINE = 4'hE,
        CMD_WRITE_INV = 4'hF
    } pci_cmd_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_REQ  = 2'b01,
        ST_ADDR = 2'b10,
        ST_DATA = 2'b11
    } xfer_state_t;

endpackage : cmdsel_pkg

// [logic/line_size_calc.sv]
// Purpose: Effective cache line and burst size from the line size and burst bits
// Assumes: Sizes are counted in dwords
// Notes:   Purely combinational; burst code 7 is clamped to the 128 limit
`timescale 1ns/10ps
module line_size_calc (
    input  wire logic [7:0] cls_in,
    input  wire logic [2:0] burst_code_in,
    output logic      [7:0] line_dw_out,
    output logic      [7:0] burst_dw_out,
    output logic            cls_legal_out
);

    logic [7:0] scaled;

    // Burst size 2..128, then round line size down to a power of two
    always_comb
    begin
        burst_dw_out = (burst_code_in == 3'h7) ? 8'h80 : (8'h02 << burst_code_in);
        scaled = 8'h02;
        for (int i = 1; i < 8; i++)
        begin
            if (cls_in[i])
                scaled = 8'h01 << i; // R22
        end
        line_dw_out = (scaled < burst_dw_out) ? scaled : burst_dw_out; // R22
        // Exact power of two from 2 up, not above the burst size
        cls_legal_out = ((cls_in & (cls_in - 8'h01)) == 8'h00) && (cls_in >= 8'h02)
                        && (cls_in <= burst_dw_out); // R3
    end

endmodule : line_size_calc

// [logic/pci_master_cache_command_select.sv]
// Purpose: Pick bus command and burst length for DMA transfers from cache settings
// Assumes: Dword-aligned transfers, byte counts a multiple of four, one clock
// Notes:   Registers on AHB-Lite, zero wait states, always OKAY
// Function
// R1: Unequal move line distances force legacy behaviour
// R2: Write-invalidate needs both enable bits set
// R3: Cache commands need mode enable, legal line size
// R4: Write-invalidate needs full line in FIFO, aligned
// R5: All writes use write-invalidate when conditions hold
// R6: Write-invalidate moves at least one whole line
// R7: Write-invalidate burst: largest line multiple, capped
// R8: Recompute burst each time, shrinking toward one line
// R9: Latency expiry waits for next line boundary
// R10: Multi-line burst stops at next boundary only
// R11: Retry releases bus, rearbitrates, retries write-invalidate
// R12: Disconnect resumes; write-invalidate only when aligned
// R13: Read-line bit; cache off means read-line reads
// R14: Cache on: read-line needs burst-size remainder
// R15: Otherwise issue plain memory read
// R16: Read-multiple needs twice line size remaining
// R17: Read-multiple burst: largest capped line multiple
// R18: Read-multiple wins over read-line
// R19: Read-multiple works without read-line enabled
// R20: Line size comes from register at 0Ch
// R21: Unsupported commands ignored as target, never issued
// R22: Effective line: rounded size, min with burst
// R23: Command chosen anew at each address phase
//
// The AHB-Lite slave port and the address map were left to the implementer.
`timescale 1ns/10ps
`include "cmdsel_params.svh"
module pci_master_cache_command_select #(
    parameter int CNT_W  = 24,
    parameter int FIFO_W = 10
) (
    input  wire logic                  clk_in,
    input  wire logic                  reset_in,
    input  wire logic                  hsel_in,
    input  wire logic [31:0]           haddr_in,
    input  wire logic [1:0]            htrans_in,
    input  wire logic                  hwrite_in,
    input  wire logic [2:0]            hsize_in,
    input  wire logic [31:0]           hwdata_in,
    input  wire logic                  hready_in,
    output logic                       hreadyout_out,
    output logic                       hresp_out,
    output logic [31:0]                hrdata_out,
    input  wire logic                  start_in,
    input  wire logic                  start_write_in,
    input  wire logic                  start_opfetch_in,
    input  wire logic                  start_move_in,
    input  wire logic [31:0]           start_addr_in,
    input  wire logic [31:0]           move_other_addr_in,
    input  wire logic [CNT_W-1:0]      start_count_in,
    input  wire logic [FIFO_W-1:0]     fifo_bytes_in,
    input  wire logic                  gnt_in,
    input  wire logic                  trdy_in,
    input  wire logic                  stop_in,
    input  wire logic                  lat_expired_in,
    input  wire logic                  tgt_addr_phase_in,
    input  wire logic                  tgt_hit_in,
    input  wire logic [3:0]            tgt_cmd_in,
    output logic                       req_out,
    output logic                       frame_out,
    output logic                       addr_phase_out,
    output cmdsel_pkg::pci_cmd_t       cmd_out,
    output logic [31:0]                addr_out,
    output logic [7:0]                 burst_len_out,
    output logic                       beat_out,
    output logic                       done_out,
    output logic                       tgt_claim_out,
    output logic [3:0]                 tgt_cmd_out
);
    import cmdsel_pkg::*;

    logic              wie_r;
    logic [7:0]        dma_mode_reg_r;
    logic [7:0]        ct5_r;
    logic [7:0]        cls_r;
    logic              cache_line_mode_enable_r;
    logic [15:0]       pcicmd_r;
    logic              wr_pend_r;
    logic [7:0]        wr_addr_r;
    xfer_state_t       st_r;
    logic [31:0]       addr_r;
    logic [CNT_W-1:0]  rem_r;
    logic              write_r;
    logic              opfetch_r;
    logic              legacy_r;
    pci_cmd_t          cmd_r;
    logic [7:0]        len_r;
    logic [7:0]        beats_r;
    logic [7:0]        line_dw;
    logic [7:0]        burst_dw;
    logic              cls_legal;
    logic [9:0]        line_b;
    logic [9:0]        mask_b;
    logic              aligned;
    logic              nxt_aligned;
    logic [31:0]       addr_nxt;
    logic [CNT_W-3:0]  rem_dw;
    logic [CNT_W-3:0]  line_w;
    logic [CNT_W-3:0]  burst_w;
    logic [CNT_W-3:0]  cap;
    logic [CNT_W-3:0]  mult;
    logic              cache_on;
    logic              wi_ok;
    logic              rm_ok;
    logic              rl_ok;
    pci_cmd_t          cmd_nxt;
    logic [7:0]        len_nxt;
    logic              last_beat;
    logic              burst_end;
    logic [9:0]        dist_a;
    logic [9:0]        dist_b;
    logic              tgt_ok;

    line_size_calc u_line (
        .cls_in        (cls_r),
        .burst_code_in ({ct5_r[`BIT_CT5_BURST_EXT], dma_mode_reg_r[`BIT_DM_BURST_HI:`BIT_DM_BURST_LO]}),
        .line_dw_out   (line_dw),
        .burst_dw_out  (burst_dw),
        .cls_legal_out (cls_legal)
    );

    // Line geometry in bytes and alignment checks
    assign line_b      = {line_dw, 2'b00};
    assign mask_b      = line_b - 10'h001;
    assign aligned     = (addr_r[9:0] & mask_b) == 10'h000;
    assign addr_nxt    = addr_r + `ADDR_STEP;
    assign nxt_aligned = (addr_nxt[9:0] & mask_b) == 10'h000;
    // Distance to next line boundary, for the move misalignment test
    assign dist_a      = (10'h000 - start_addr_in[9:0]) & mask_b;
    assign dist_b      = (10'h000 - move_other_addr_in[9:0]) & mask_b;

    // Sizes in dwords; burst is a multiple of line so masking gives a multiple
    assign rem_dw   = rem_r[CNT_W-1:2];
    assign line_w   = {{(CNT_W-10){1'b0}}, line_dw};
    assign burst_w  = {{(CNT_W-10){1'b0}}, burst_dw};
    assign cap      = (rem_dw < burst_w) ? rem_dw : burst_w; // R8
    assign mult     = cap & ~(line_w - {{(CNT_W-3){1'b0}}, 1'b1}); // R7 R17

    // Command conditions
    assign cache_on = cache_line_mode_enable_r & cls_legal & ~legacy_r; // R1 R3
    assign wi_ok    = write_r & wie_r & pcicmd_r[`BIT_PCICMD_MWI] & cache_on // R2
                      & (fifo_bytes_in >= line_b) & aligned // R4 R12
                      & (rem_dw >= line_w); // R6
    assign rm_ok    = ~write_r & ~opfetch_r & dma_mode_reg_r[`BIT_DM_READ_MULTI] & cache_on
                      & aligned & (rem_dw >= (line_w << 1)); // R16 R19
    // Legacy read-line when cache mode is off or the move is misaligned
    assign rl_ok    = ~write_r & ~opfetch_r & dma_mode_reg_r[`BIT_DM_READ_LINE]
                      & ((~cache_line_mode_enable_r | legacy_r) // R13
                      | (cache_on & aligned & (rem_dw >= burst_w))); // R14

    // Command and length chosen for the coming address phase
    always_comb
    begin
        cmd_nxt = write_r ? CMD_MEM_WRITE : CMD_MEM_READ; // R15 R21
        len_nxt = cap[7:0];
        if (wi_ok)
        begin
            cmd_nxt = CMD_WRITE_INV; // R5
            len_nxt = mult[7:0]; // R7
        end
        else if (rm_ok)
        begin
            cmd_nxt = CMD_READ_MULT; // R18
            len_nxt = mult[7:0]; // R17
        end
        else if (rl_ok)
        begin
            cmd_nxt = CMD_READ_LINE;
        end
    end

    // End of burst: count done, data out, target stop, or latency expiry
    assign last_beat = (beats_r + 8'h01 == len_r) || (rem_r == `DWORD_BYTES);
    assign burst_end = last_beat || stop_in
                       || (lat_expired_in && ((cmd_r != CMD_WRITE_INV) || nxt_aligned)); // R9 R10

    // Transfer sequencer
    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            st_r      <= ST_IDLE;
            addr_r    <= 32'h00000000;
            rem_r     <= '0;
            write_r   <= 1'b0;
            opfetch_r <= 1'b0;
            legacy_r  <= 1'b0;
            cmd_r     <= CMD_MEM_READ;
            len_r     <= 8'h00;
            beats_r   <= 8'h00;
            done_out  <= 1'b0;
        end
        else
        begin
            done_out <= 1'b0;
            unique case (st_r)
                ST_IDLE:
                begin
                    if (start_in && (start_count_in != '0))
                    begin
                        st_r      <= ST_REQ;
                        addr_r    <= start_addr_in;
                        rem_r     <= start_count_in;
                        write_r   <= start_write_in;
                        opfetch_r <= start_opfetch_in;
                        legacy_r  <= start_move_in && (dist_a != dist_b); // R1
                    end
                end
                ST_REQ:
                begin
                    // Bus mastering must be enabled before a grant is used
                    if (gnt_in && pcicmd_r[`BIT_PCICMD_MASTER])
                    begin
                        st_r    <= ST_ADDR;
                        cmd_r   <= cmd_nxt; // R23
                        len_r   <= len_nxt; // R8
                        beats_r <= 8'h00;
                    end
                end
                ST_ADDR:
                begin
                    st_r <= ST_DATA;
                end
                ST_DATA:
                begin
                    if (stop_in && !trdy_in)
                    begin
                        st_r <= ST_REQ; // R11
                    end
                    else if (trdy_in)
                    begin
                        addr_r  <= addr_nxt;
                        rem_r   <= rem_r - `DWORD_BYTES;
                        beats_r <= beats_r + 8'h01;
                        if (rem_r == `DWORD_BYTES)
                        begin
                            st_r     <= ST_IDLE;
                            done_out <= 1'b1;
                        end
                        else if (burst_end)
                        begin
                            st_r <= ST_REQ; // R12
                        end
                    end
                end
            endcase
        end
    end

    // Bus-facing outputs
    assign req_out        = (st_r == ST_REQ) && pcicmd_r[`BIT_PCICMD_MASTER];
    assign frame_out      = (st_r == ST_ADDR) || (st_r == ST_DATA);
    assign addr_phase_out = (st_r == ST_ADDR);
    assign beat_out       = (st_r == ST_DATA) && trdy_in;
    assign cmd_out        = cmd_r;
    assign addr_out       = addr_r;
    assign burst_len_out  = len_r;

    // Target side: only the supported command set is claimed
    always_comb
    begin
        unique case (tgt_cmd_in)
            CMD_IO_READ, CMD_IO_WRITE, CMD_MEM_READ, CMD_MEM_WRITE,
            CMD_CFG_READ, CMD_CFG_WRITE, CMD_READ_MULT, CMD_READ_LINE,
            CMD_WRITE_INV: tgt_ok = 1'b1;
            default:       tgt_ok = 1'b0; // R21
        endcase
    end

    // Cache commands fall back to plain read or write as target
    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            tgt_claim_out <= 1'b0;
            tgt_cmd_out   <= 4'h0;
        end
        else
        begin
            tgt_claim_out <= tgt_addr_phase_in && tgt_hit_in && tgt_ok; // R21
            if (tgt_cmd_in == CMD_READ_MULT || tgt_cmd_in == CMD_READ_LINE)
                tgt_cmd_out <= CMD_MEM_READ;
            else if (tgt_cmd_in == CMD_WRITE_INV)
                tgt_cmd_out <= CMD_MEM_WRITE;
            else
                tgt_cmd_out <= tgt_cmd_in;
        end
    end

    // AHB-Lite: zero wait states, never an error
    assign hreadyout_out = 1'b1;
    assign hresp_out     = 1'b0;

    // Register writes land in the data phase
    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
            wie_r     <= 1'b0;
            dma_mode_reg_r   <= `RST_REG8;
            ct5_r     <= `RST_REG8;
            cls_r     <= `RST_REG8;
            cache_line_mode_enable_r    <= 1'b0;
            pcicmd_r  <= `RST_PCICMD;
        end
        else
        begin
            wr_pend_r <= hsel_in && hready_in && htrans_in[1] && hwrite_in;
            wr_addr_r <= haddr_in[7:0];
            if (wr_pend_r)
            begin
                unique case (wr_addr_r)
                    `OFS_CHIP_TEST_THREE: wie_r    <= hwdata_in[`BIT_WR_INV_EN];
                    `OFS_DMA_MODE:        dma_mode_reg_r  <= hwdata_in[7:0];
                    `OFS_CHIP_TEST_FIVE:  ct5_r    <= hwdata_in[7:0];
                    `OFS_CACHE_LINE_SIZE: cls_r    <= hwdata_in[7:0]; // R20
                    `OFS_CACHE_CTRL:      cache_line_mode_enable_r   <= hwdata_in[`BIT_CACHE_MODE_EN];
                    `OFS_PCI_COMMAND:     pcicmd_r <= hwdata_in[15:0];
                    default:              ;
                endcase
            end
        end
    end

    // Read data captured at the address phase; unmapped reads zero
    always_ff @(posedge clk_in)
    begin
        if (reset_in)
            hrdata_out <= 32'h00000000;
        else if (hsel_in && hready_in && htrans_in[1] && !hwrite_in)
        begin
            unique case (haddr_in[7:0])
                `OFS_CHIP_TEST_THREE: hrdata_out <= {31'h0, wie_r};
                `OFS_DMA_MODE:        hrdata_out <= {24'h0, dma_mode_reg_r};
                `OFS_CHIP_TEST_FIVE:  hrdata_out <= {24'h0, ct5_r};
                `OFS_CACHE_LINE_SIZE: hrdata_out <= {24'h0, cls_r};
                `OFS_CACHE_CTRL:      hrdata_out <= {31'h0, cache_line_mode_enable_r};
                `OFS_PCI_COMMAND:     hrdata_out <= {16'h0, pcicmd_r};
                `OFS_STATUS:          hrdata_out <= {line_dw, len_r, 3'h0, legacy_r,
                                                     cmd_r, 6'h0, st_r};
                default:              hrdata_out <= 32'h00000000;
            endcase
        end
    end

    // Checks on the driven command stream and the target claim
    a_wi_enables: assert property (@(posedge clk_in) disable iff (reset_in)
        addr_phase_out && cmd_out == CMD_WRITE_INV |-> wie_r && pcicmd_r[`BIT_PCICMD_MWI]
            && cache_line_mode_enable_r && cls_legal)
        else $error("write-invalidate without enables"); // R2
    a_wi_whole_line: assert property (@(posedge clk_in) disable iff (reset_in)
        addr_phase_out && cmd_out == CMD_WRITE_INV |-> aligned && len_r >= line_dw
            && (len_r & (line_dw - 8'h01)) == 8'h00 && len_r <= burst_dw)
        else $error("write-invalidate burst not whole lines"); // R6
    a_legacy_move: assert property (@(posedge clk_in) disable iff (reset_in)
        addr_phase_out && legacy_r |-> cmd_out != CMD_WRITE_INV && cmd_out != CMD_READ_MULT)
        else $error("cache command on misaligned move"); // R1
    a_opfetch_plain: assert property (@(posedge clk_in) disable iff (reset_in)
        addr_phase_out && opfetch_r |-> cmd_out == CMD_MEM_READ)
        else $error("opcode fetch not a plain read"); // R13
    a_master_cmds: assert property (@(posedge clk_in) disable iff (reset_in)
        addr_phase_out |-> cmd_out inside {CMD_MEM_READ, CMD_MEM_WRITE, CMD_READ_LINE,
            CMD_READ_MULT, CMD_WRITE_INV})
        else $error("unsupported master command"); // R21
    a_rm_over_rl: assert property (@(posedge clk_in) disable iff (reset_in)
        st_r == ST_REQ && gnt_in && pcicmd_r[`BIT_PCICMD_MASTER] && rm_ok
            |=> cmd_out == CMD_READ_MULT ##1 addr_phase_out == 1'b0)
        else $error("read-multiple not chosen"); // R18
    a_retry_rearb: assert property (@(posedge clk_in) disable iff (reset_in)
        st_r == ST_DATA && stop_in && !trdy_in |=> !frame_out && st_r == ST_REQ)
        else $error("retry did not rearbitrate"); // R11
    a_lat_hold: assert property (@(posedge clk_in) disable iff (reset_in)
        st_r == ST_DATA && trdy_in && lat_expired_in && cmd_r == CMD_WRITE_INV
            && !nxt_aligned && !last_beat && !stop_in |=> frame_out && st_r == ST_DATA)
        else $error("write-invalidate left before line boundary"); // R9
    a_tgt_ignore: assert property (@(posedge clk_in) disable iff (reset_in)
        tgt_addr_phase_in && !tgt_ok |=> !tgt_claim_out)
        else $error("unsupported command claimed"); // R21

endmodule : pci_master_cache_command_select

// [sim/pci_target_model.sv]
// Purpose: Arbiter and memory target facing the command selector
// Assumes: Active-high handshakes on one clock, grant follows request
// Notes:   Released handshakes fall to the deasserted level
`timescale 1ns/10ps
module pci_target_model (
    input  wire logic clk_in,
    input  wire logic reset_in,
    input  wire logic req_in,
    input  wire logic frame_in,
    input  wire logic slow_in,
    input  wire logic retry_in,
    output logic      gnt_out,
    output logic      trdy_out,
    output logic      stop_out
);
    logic used_r;

    // Grant one cycle after request; slow mode gives a beat every other cycle
    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            gnt_out  <= 1'b0;
            trdy_out <= 1'b0;
            stop_out <= 1'b0;
            used_r   <= 1'b0;
        end
        else
        begin
            gnt_out  <= req_in;
            trdy_out <= frame_in & ~(retry_in & ~used_r) & (~slow_in | ~trdy_out);
            stop_out <= frame_in & retry_in & ~used_r;
            used_r   <= retry_in & (used_r | frame_in);
        end
    end
endmodule : pci_target_model

// [sim/tb_pci_master_cache_command_select.sv]
// Purpose: Self-checking bench for the cache-aware command selector
// Assumes: Zero-wait AHB-Lite slave, partner model grants every request
// Notes:   Commands checked at each address phase, burst lengths sampled at the first two
`timescale 1ns/10ps
`include "cmdsel_params.svh"
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin fails++; \
    $display("wrong value at %0t: got %h expected %h", $time, a, e); end end
module tb_pci_master_cache_command_select;
    import cmdsel_pkg::*;
    logic        clk_in, reset_in, hsel_in, hwrite_in, start_in, start_write_in;
    logic        start_opfetch_in, start_move_in, gnt_in, trdy_in, stop_in, lat_expired_in;
    logic        tgt_addr_phase_in, tgt_hit_in, hreadyout_out, hresp_out, req_out;
    logic        frame_out, addr_phase_out, beat_out, done_out, tgt_claim_out, slow, retry;
    logic [1:0]  htrans_in;
    logic [2:0]  hsize_in;
    logic [3:0]  tgt_cmd_in, tgt_cmd_out, exp_tc, cmd_a, cmd_b;
    logic [7:0]  burst_len_out, len_a, len_b;
    logic [9:0]  fifo_bytes_in;
    logic [23:0] start_count_in;
    logic [31:0] haddr_in, hwdata_in, hrdata_out, start_addr_in, move_other_addr_in, rd;
    logic [31:0] addr_out, addr_b;
    pci_cmd_t    cmd_out;
    int          fails, n_tests, beats_a;
    // Read table: mode, cache on, opcode fetch, byte count, command
    logic [7:0]  t_dm[7] = '{8'h84, 8'h8C, 8'h88, 8'h88, 8'h88, 8'h88, 8'h80};
    logic        t_ce[7] = '{1, 1, 1, 1, 1, 0, 1};
    logic        t_op[7] = '{0, 0, 0, 0, 1, 0, 0};
    logic [23:0] t_n[7]  = '{24'h40, 24'h40, 24'h40, 24'h10, 24'h40, 24'h10, 24'h40};
    logic [3:0]  t_c[7]  = '{4'hC, 4'hC, 4'hE, 4'h6, 4'h6, 4'hE, 4'h6};

    pci_master_cache_command_select uut (
        .clk_in, .reset_in, .hsel_in, .haddr_in, .htrans_in, .hwrite_in, .hsize_in,
        .hwdata_in, .hready_in(hreadyout_out), .hreadyout_out, .hresp_out, .hrdata_out,
        .start_in, .start_write_in, .start_opfetch_in, .start_move_in, .start_addr_in,
        .move_other_addr_in, .start_count_in, .fifo_bytes_in, .gnt_in, .trdy_in, .stop_in,
        .lat_expired_in, .tgt_addr_phase_in, .tgt_hit_in, .tgt_cmd_in, .req_out, .frame_out,
        .addr_phase_out, .cmd_out, .addr_out, .burst_len_out, .beat_out, .done_out,
        .tgt_claim_out, .tgt_cmd_out);
    pci_target_model far_end (
        .clk_in(clk_in), .reset_in(reset_in), .req_in(req_out), .frame_in(frame_out),
        .slow_in(slow), .retry_in(retry), .gnt_out(gnt_in), .trdy_out(trdy_in),
        .stop_out(stop_in));

    initial
    begin
        clk_in = 1'b0;
        forever #10 clk_in = ~clk_in;
    end

    // Master never drives a command outside the I/O and memory command set
    always @(posedge clk_in)
        if (addr_phase_out === 1'b1) `CHK(16'hD0CC >> cmd_out & 16'h1, 16'h1)

    task automatic summarize;
        $display("comparisons %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : summarize

    // Bounded wait for the slave's ready; a hang ends the run
    task automatic wait_rdy;
        @(posedge clk_in);
        for (int i = 0; hreadyout_out !== 1'b1; i++)
        begin
            if (i > 20)
            begin
                fails++;
                summarize();
            end
            @(posedge clk_in);
        end
    endtask : wait_rdy

    task automatic ahb(input logic wr, input logic [7:0] ofs, input logic [31:0] wd);
        hsel_in   <= 1'b1;
        htrans_in <= 2'b10;
        haddr_in  <= {24'h000000, ofs};
        hwrite_in <= wr;
        wait_rdy();
        htrans_in <= 2'b00;
        hwdata_in <= wd;
        wait_rdy();
        rd = hrdata_out;
        `CHK(hresp_out, 1'b0)
    endtask : ahb

    // One transfer to done, first two ownerships recorded
    task automatic xfer(input logic wr, op, mv, input logic [31:0] a, input logic [23:0] n);
        int ph;
        start_in         <= 1'b1;
        start_write_in   <= wr;
        start_opfetch_in <= op;
        start_move_in    <= mv;
        start_addr_in    <= a;
        start_count_in   <= n;
        @(posedge clk_in);
        start_in <= 1'b0;
        ph = 0;
        beats_a = 0;
        for (int i = 0; done_out !== 1'b1; i++)
        begin
            if (i > 600)
            begin
                fails++;
                summarize();
            end
            @(posedge clk_in);
            if (addr_phase_out === 1'b1)
                ph++;
            if (addr_phase_out === 1'b1 && ph == 1)
                {cmd_a, len_a} = {cmd_out, burst_len_out};
            if (addr_phase_out === 1'b1 && ph == 2)
                {cmd_b, len_b, addr_b} = {cmd_out, burst_len_out, addr_out};
            if (beat_out === 1'b1 && ph == 1)
                beats_a++;
        end
    endtask : xfer

    initial
    begin
        {fails, n_tests} = 0;
        {hsel_in, hwrite_in, start_in, start_write_in, start_opfetch_in, start_move_in} = 0;
        {lat_expired_in, tgt_addr_phase_in, tgt_hit_in, slow, retry, htrans_in} = 0;
        {tgt_cmd_in, haddr_in, hwdata_in, start_addr_in, start_count_in} = 0;
        {hsize_in, fifo_bytes_in, move_other_addr_in} = {3'b010, 10'h200, 32'h00000204};
        reset_in = 1'b1;
        repeat (3) @(posedge clk_in);
        reset_in <= 1'b0;
        ahb(0, `OFS_DMA_MODE, 0);
        `CHK(rd, 32'h00000000)
        ahb(0, 8'h40, 0);
        `CHK(rd, 32'h00000000)
        ahb(1, `OFS_CACHE_LINE_SIZE, 32'h0000000C);
        ahb(1, `OFS_DMA_MODE, 32'h000000C0);
        ahb(0, `OFS_STATUS, 0);
        `CHK(rd[31:24], 8'h08)
        $display("test register access done");
        // Line 4 dwords, burst 8, all write-invalidate enables
        ahb(1, `OFS_CACHE_LINE_SIZE, 32'h00000004);
        ahb(1, `OFS_DMA_MODE, 32'h00000080);
        ahb(1, `OFS_CACHE_CTRL, 32'h00000001);
        ahb(1, `OFS_CHIP_TEST_THREE, 32'h00000001);
        ahb(1, `OFS_PCI_COMMAND, 32'h00000014);
        xfer(1, 0, 0, 32'h00000100, 24'h000030);
        `CHK({cmd_a, len_a, cmd_b, len_b}, {CMD_WRITE_INV, 8'h08, CMD_WRITE_INV, 8'h04})
        lat_expired_in <= 1'b1;
        xfer(1, 0, 0, 32'h00000100, 24'h000030);
        `CHK(beats_a, 4)
        lat_expired_in <= 1'b0;
        retry <= 1'b1;
        xfer(1, 0, 0, 32'h00000100, 24'h000010);
        `CHK({cmd_a, cmd_b, beats_a}, {CMD_WRITE_INV, CMD_WRITE_INV, 32'd0})
        `CHK(addr_b, 32'h00000100)
        retry <= 1'b0;
        xfer(1, 0, 0, 32'h00000104, 24'h000010);
        `CHK(cmd_a, CMD_MEM_WRITE)
        fifo_bytes_in <= 10'h008;
        xfer(1, 0, 0, 32'h00000100, 24'h000010);
        `CHK(cmd_a, CMD_MEM_WRITE)
        fifo_bytes_in <= 10'h200;
        xfer(1, 0, 1, 32'h00000100, 24'h000010);
        `CHK(cmd_a, CMD_MEM_WRITE)
        ahb(1, `OFS_PCI_COMMAND, 32'h00000004);
        xfer(1, 0, 0, 32'h00000100, 24'h000010);
        `CHK(cmd_a, CMD_MEM_WRITE)
        ahb(1, `OFS_PCI_COMMAND, 32'h00000014);
        ahb(1, `OFS_CACHE_LINE_SIZE, 32'h00000000);
        xfer(1, 0, 0, 32'h00000100, 24'h000010);
        `CHK(cmd_a, CMD_MEM_WRITE)
        ahb(1, `OFS_CACHE_LINE_SIZE, 32'h00000004);
        $display("test write commands done");
        // Slow target stretches read bursts
        slow <= 1'b1;
        for (int k = 0; k < 7; k++)
        begin
            ahb(1, `OFS_DMA_MODE, {24'h000000, t_dm[k]});
            ahb(1, `OFS_CACHE_CTRL, {31'h0, t_ce[k]});
            xfer(0, t_op[k], 0, 32'h00000100, t_n[k]);
            `CHK({cmd_a, len_a}, {t_c[k], t_n[k] == 24'h40 ? 8'h08 : 8'h04})
        end
        $display("test read commands done");
        // Target side: claims and folded commands
        tgt_hit_in <= 1'b1;
        for (int k = 0; k < 16; k++)
        begin
            tgt_addr_phase_in <= 1'b1;
            tgt_cmd_in <= 4'(k);
            @(posedge clk_in);
            tgt_addr_phase_in <= 1'b0;
            @(posedge clk_in);
            exp_tc = (k == 12 || k == 14) ? 4'h6 : (k == 15 ? 4'h7 : 4'(k));
            `CHK(tgt_claim_out, 1'(16'hDCCC >> k))
            if (tgt_claim_out === 1'b1)
                `CHK(tgt_cmd_out, exp_tc)
        end
        $display("test target commands done");
        summarize();
    end
endmodule : tb_pci_master_cache_command_select
